// File: inc/lcdsp_params.svh
// Purpose: Constants of the LCD driver serial host port
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Definitions only
`ifndef LCDSP_PARAMS_SVH
`define LCDSP_PARAMS_SVH

// ************************************************************
// Interface select codes
// ************************************************************
`define LCDSP_SEL_SPI3 2'h0
`define LCDSP_SEL_SPI4 2'h1
`define LCDSP_SEL_I2C  2'h2
`define LCDSP_SEL_SER9 2'h3

// ************************************************************
// Positions in the pin synchroniser vector
// ************************************************************
`define LCDSP_P_CS   0
`define LCDSP_P_SCK  1
`define LCDSP_P_SIN  2
`define LCDSP_P_DC   3
`define LCDSP_P_HRN  4
`define LCDSP_P_MX   5
`define LCDSP_P_SEL0 6
`define LCDSP_P_SEL1 7
`define LCDSP_P_SA0  8
`define LCDSP_P_SA1  9
`define LCDSP_SYNC_RST 10'h011

// ************************************************************
// Address space and framing
// ************************************************************
`define LCDSP_X_LAST   7'h5F
`define LCDSP_Y_LAST   5'h10
`define LCDSP_BIT_LAST 3'h7

// ************************************************************
// Opcodes seen by the port itself
// ************************************************************
`define LCDSP_OP_LEN     8'hE0
`define LCDSP_OP_SETX    8'hE1
`define LCDSP_OP_SETY    3'h1
`define LCDSP_OP_RD_IDA  8'hD0
`define LCDSP_OP_RD_IDB  8'hD1
`define LCDSP_OP_RD_IDC  8'hD2
`define LCDSP_OP_RD_IDD  8'hD3
`define LCDSP_OP_RD_VM   8'hD4
`define LCDSP_OP_RD_TEMP 8'hD5

`endif

// File: inc/lcdsp_pkg.sv
// Purpose: Types of the LCD driver serial host port
// Assumes: Constants live in lcdsp_params.svh
// Notes:   Types only
`default_nettype none

package lcdsp_pkg;

  typedef enum logic [2:0] {
    IDLE = 3'h0,
    FLAG = 3'h1,
    BITS = 3'h3,
    READ = 3'h2,
    HOLD = 3'h6
  } lcdsp_state_t;

  typedef enum logic [1:0] {
    ARG_NONE = 2'h0,
    ARG_LEN  = 2'h1,
    ARG_SETX = 2'h2
  } lcdsp_arg_t;

  typedef struct packed {
    logic [6:0] col;
    logic [4:0] bank;
    logic [7:0] data;
  } lcdsp_ram_wr_t;

  typedef struct packed {
    logic [9:0]    pinS1;
    logic [9:0]    pinS2;
    logic          clkD;
    lcdsp_state_t  state;
    logic [2:0]    bitCnt;
    logic [7:0]    shiftIn;
    logic          flag;
    logic [7:0]    dataLeft;
    lcdsp_arg_t    argWait;
    logic [7:0]    txShift;
    logic          serialOut;
    logic          serialOutEn;
    logic [6:0]    xAddr;
    logic [4:0]    yAddr;
    logic          cmdValid;
    logic [7:0]    cmdByte;
    logic          ramWrValid;
    lcdsp_ram_wr_t ramWr;
  } lcdsp_regs_t;

endpackage : lcdsp_pkg

`default_nettype wire

// File: design/lcdsp_host_port.sv
// Purpose: Serial host port of a grey-scale matrix LCD driver
// Assumes: Pins are asynchronous to sys_clk; serial clock far slower
// Notes:   I2C mode only parks this port; command set lives outside
//
// Behaviour
// - Vertical flip bit set maps Y address 0 to the bottom bank.
// - Horizontal flip pin set maps X address 0 to the rightmost column.
// - Select pins pick 3-line SPI, 4-line SPI, I2C or 9-bit serial.
// - 4-line SPI: data/command pin high means display data, low command.
// - 3-line SPI: length command counts 1..255 data bytes, then commands.
// - Chip select high mid-stream drops partial byte; in 3-line SPI next byte is command.
// - Read status command makes device answer; host then raises select.
// - Input sampled on rising serial clock, output changed on falling.
// - 9-bit packet: flag bit then byte; low command, high RAM data.
// - Address counter advances after every display data byte.
// - Bytes travel most significant bit first; commands in any order.
// - Select high holds receiver idle; falling select starts transfer.
// - 9-bit mode captures flag on first rising clock of packet.
// - Select still low after a byte: next rising edge is flag bit.
// - Hardware reset aborts transfer, clears state; then expects flag.
// - Eighth read bit held until last rising edge, then output released.
// - Bit reads return D7 undefined and the chosen bit in D6..D0.
// - Two identity bits fixed, two taken from strap pads.
// - Temperature read returns D7 undefined, seven-bit code in D6..D0.
`timescale 1ns/100ps
`default_nettype none
`include "lcdsp_params.svh"

module lcdsp_host_port #(
  // Arbitrary values for the hard-wired identity bits
  parameter logic FIXED_ID_A = 1'b1,
  parameter logic FIXED_ID_B = 1'b0
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // Serial pins
  input  wire logic                   chipSelectN,
  input  wire logic                   serialClk,
  input  wire logic                   serialInPin,
  input  wire logic                   dataCmdPin,
  input  wire logic                   hardwareResetN,
  output var  logic                   serialOutPin,
  output var  logic                   serialOutEn,
  // Configuration pins and bits
  input  wire logic [1:0]             interfaceSelectPins,
  input  wire logic                   horizontalFlipPin,
  input  wire logic                   strapPadLow,
  input  wire logic                   strapPadHigh,
  input  wire logic                   verticalFlipBit,
  // Readback sources
  input  wire logic                   voltageModeReadback,
  input  wire logic [6:0]             temperatureCode,
  // Decoded traffic
  output var  logic                   cmdValid,
  output var  logic [7:0]             cmdByte,
  output var  logic                   ramWrValid,
  output var  lcdsp_pkg::lcdsp_ram_wr_t ramWrite
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [6:0] mirror(input logic [6:0] a,
                                        input logic [6:0] last,
                                        input logic       flip);
    mirror = flip ? 7'(last - a) : a;
  endfunction : mirror

  lcdsp_pkg::lcdsp_regs_t r_r;
  lcdsp_pkg::lcdsp_regs_t r_nxt;

  logic       clkRise;
  logic       clkFall;
  logic       csHigh;
  logic       hwResetN;
  logic [1:0] sel;
  logic       sinS;
  logic       nineBit;
  logic [7:0] byteIn;
  logic       isData;
  logic [6:0] colM;
  logic [6:0] bankM;
  logic       isRead;
  logic [7:0] respByte;
  logic       byteDone;

  assign clkRise  = r_r.pinS2[`LCDSP_P_SCK] & ~r_r.clkD;
  assign clkFall  = ~r_r.pinS2[`LCDSP_P_SCK] & r_r.clkD;
  assign csHigh   = r_r.pinS2[`LCDSP_P_CS];
  assign hwResetN = r_r.pinS2[`LCDSP_P_HRN];
  assign sel      = {r_r.pinS2[`LCDSP_P_SEL1], r_r.pinS2[`LCDSP_P_SEL0]};
  assign sinS     = r_r.pinS2[`LCDSP_P_SIN];
  assign nineBit  = (sel == `LCDSP_SEL_SER9);
  assign byteIn   = {r_r.shiftIn[6:0], sinS};
  assign byteDone = hwResetN && !csHigh && sel != `LCDSP_SEL_I2C
                    && r_r.state == lcdsp_pkg::BITS && clkRise
                    && r_r.bitCnt == `LCDSP_BIT_LAST;

  // Data or command, per selected mode
  assign isData = (sel == `LCDSP_SEL_SPI4) ? r_r.pinS2[`LCDSP_P_DC]
                : (sel == `LCDSP_SEL_SPI3) ? (r_r.dataLeft != 8'h00)
                : r_r.flag;

  assign colM  = mirror(r_r.xAddr, `LCDSP_X_LAST,
                        r_r.pinS2[`LCDSP_P_MX]);
  assign bankM = mirror({2'h0, r_r.yAddr}, {2'h0, `LCDSP_Y_LAST},
                        verticalFlipBit);

  // ************************************************************
  // Readback decode
  // ************************************************************
  always_comb
  begin
    isRead   = 1'b1;
    respByte = 8'h00;
    unique case (byteIn)
      `LCDSP_OP_RD_IDA:  respByte = {1'b0, {7{FIXED_ID_A}}};
      `LCDSP_OP_RD_IDB:  respByte = {1'b0, {7{FIXED_ID_B}}};
      `LCDSP_OP_RD_IDC:  respByte = {1'b0,
                                     {7{r_r.pinS2[`LCDSP_P_SA0]}}};
      `LCDSP_OP_RD_IDD:  respByte = {1'b0,
                                     {7{r_r.pinS2[`LCDSP_P_SA1]}}};
      `LCDSP_OP_RD_VM:   respByte = {1'b0, {7{voltageModeReadback}}};
      `LCDSP_OP_RD_TEMP: respByte = {1'b0, temperatureCode};
      default:           isRead   = 1'b0;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.cmdValid   = 1'b0;
    r_nxt.ramWrValid = 1'b0;
    if (!hwResetN)
    begin
      // Clears all but the synchronisers, so a low select afterwards in 9-bit mode expects a flag
      r_nxt = '0;
    end
    else if (csHigh || sel == `LCDSP_SEL_I2C)
    begin
      // Partial byte is simply forgotten; written bytes stand
      r_nxt.state       = lcdsp_pkg::IDLE;
      r_nxt.bitCnt      = 3'h0;
      r_nxt.dataLeft    = 8'h00;
      r_nxt.argWait     = lcdsp_pkg::ARG_NONE;
      r_nxt.serialOutEn = 1'b0;
    end
    else
    begin
      unique case (r_r.state)
        lcdsp_pkg::IDLE:
        begin
          r_nxt.bitCnt = 3'h0;
          r_nxt.state  = nineBit ? lcdsp_pkg::FLAG : lcdsp_pkg::BITS;
        end
        lcdsp_pkg::FLAG:
          if (clkRise)
          begin
            r_nxt.flag  = sinS;
            r_nxt.state = lcdsp_pkg::BITS;
          end
        lcdsp_pkg::BITS:
          if (clkRise)
          begin
            r_nxt.shiftIn = byteIn;
            r_nxt.bitCnt  = 3'(r_r.bitCnt + 3'h1);
            if (byteDone)
            begin
              r_nxt.state = nineBit ? lcdsp_pkg::FLAG
                                    : lcdsp_pkg::BITS;
              if (isData)
              begin
                r_nxt.ramWrValid = 1'b1;
                r_nxt.ramWr      = '{colM, bankM[4:0], byteIn};
                if (sel == `LCDSP_SEL_SPI3)
                  r_nxt.dataLeft = 8'(r_r.dataLeft - 8'h01);
                if (r_r.xAddr == `LCDSP_X_LAST)
                begin
                  r_nxt.xAddr = 7'h00;
                  r_nxt.yAddr = (r_r.yAddr == `LCDSP_Y_LAST) ? 5'h00
                                : 5'(r_r.yAddr + 5'h01);
                end
                else
                  r_nxt.xAddr = 7'(r_r.xAddr + 7'h01);
              end
              else if (r_r.argWait == lcdsp_pkg::ARG_LEN)
              begin
                r_nxt.dataLeft = byteIn;
                r_nxt.argWait  = lcdsp_pkg::ARG_NONE;
              end
              else if (r_r.argWait == lcdsp_pkg::ARG_SETX)
              begin
                r_nxt.xAddr   = byteIn[6:0];
                r_nxt.argWait = lcdsp_pkg::ARG_NONE;
              end
              else if (byteIn == `LCDSP_OP_LEN)
                r_nxt.argWait = lcdsp_pkg::ARG_LEN;
              else if (byteIn == `LCDSP_OP_SETX)
                r_nxt.argWait = lcdsp_pkg::ARG_SETX;
              else if (byteIn[7:5] == `LCDSP_OP_SETY)
                r_nxt.yAddr = byteIn[4:0];
              else if (isRead)
              begin
                // Host has let go of the line by the next falling edge
                r_nxt.txShift = respByte;
                r_nxt.state   = lcdsp_pkg::READ;
              end
              else
              begin
                r_nxt.cmdValid = 1'b1;
                r_nxt.cmdByte  = byteIn;
              end
            end
          end
        lcdsp_pkg::READ:
        begin
          if (clkFall)
          begin
            r_nxt.serialOut   = r_r.txShift[7];
            r_nxt.txShift     = {r_r.txShift[6:0], 1'b0};
            r_nxt.serialOutEn = 1'b1;
          end
          if (clkRise)
          begin
            r_nxt.bitCnt = 3'(r_r.bitCnt + 3'h1);
            if (r_r.bitCnt == `LCDSP_BIT_LAST)
            begin
              // Only a select high, I2C select or hardware reset frees the port for a new command
              r_nxt.serialOutEn = 1'b0;
              r_nxt.state       = lcdsp_pkg::HOLD;
            end
          end
        end
        lcdsp_pkg::HOLD:
          r_nxt.serialOutEn = 1'b0;
      endcase
    end
    // Synchronisers run through the hardware reset; reset loads LCDSP_SYNC_RST
    r_nxt.pinS1 = {strapPadHigh, strapPadLow, interfaceSelectPins,
                   horizontalFlipPin, hardwareResetN, dataCmdPin,
                   serialInPin, serialClk, chipSelectN};
    r_nxt.pinS2 = r_r.pinS1;
    r_nxt.clkD  = r_r.pinS2[`LCDSP_P_SCK];
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      r_r       <= '0;
      r_r.pinS1 <= `LCDSP_SYNC_RST;
      r_r.pinS2 <= `LCDSP_SYNC_RST;
    end
    else
      r_r <= r_nxt;
  end

  assign serialOutPin = r_r.serialOut;
  assign serialOutEn  = r_r.serialOutEn;
  assign cmdValid     = r_r.cmdValid;
  assign cmdByte      = r_r.cmdByte;
  assign ramWrValid   = r_r.ramWrValid;
  assign ramWrite     = r_r.ramWr;

  // ************************************************************
  // Checks
  // ************************************************************
  cs_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
    csHigh && hwResetN |=> r_r.state == lcdsp_pkg::IDLE
                           && r_r.dataLeft == 8'h00)
    else $error("receiver not idle under high select");

  col_mirror_a: assert property (@(posedge sys_clk) disable iff (reset)
    byteDone && isData |=> ramWrValid && ramWrite.col ==
      ($past(r_r.pinS2[`LCDSP_P_MX]) ? 7'(`LCDSP_X_LAST - $past(r_r.xAddr))
                                     : $past(r_r.xAddr)))
    else $error("column mirror wrong");

  bank_mirror_a: assert property (@(posedge sys_clk)
    disable iff (reset) byteDone && isData |=> ramWrite.bank ==
      ($past(verticalFlipBit) ? 5'(`LCDSP_Y_LAST - $past(r_r.yAddr))
                              : $past(r_r.yAddr)))
    else $error("bank mirror wrong");

  addr_step_a: assert property (@(posedge sys_clk) disable iff (reset)
    ramWrValid && $past(hwResetN) |-> r_r.xAddr ==
      (($past(r_r.xAddr) == `LCDSP_X_LAST) ? 7'h00
                                            : 7'($past(r_r.xAddr) + 7'h01)))
    else $error("address counter did not advance");

  out_on_fall_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    serialOutEn && $changed(serialOutPin) |-> $past(clkFall))
    else $error("output changed off a falling edge");

  release_a: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(serialOutEn) |-> $past(clkRise) || $past(csHigh)
                           || !$past(hwResetN)
                           || $past(sel) == `LCDSP_SEL_I2C)
    else $error("output released at wrong moment");

  flag_capture_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    r_r.state == lcdsp_pkg::FLAG && clkRise && !csHigh && hwResetN
    && nineBit |=> r_r.state == lcdsp_pkg::BITS && r_r.flag == $past(sinS))
    else $error("flag not captured on first rising edge");

  next_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
    byteDone && nineBit && !isRead |=> r_r.state == lcdsp_pkg::FLAG)
    else $error("next packet does not start with a flag");

  hw_reset_a: assert property (@(posedge sys_clk) disable iff (reset)
    !hwResetN |=> !serialOutEn && !cmdValid && !ramWrValid
                  && r_r.xAddr == 7'h00)
    else $error("hardware reset did not clear the port");

endmodule : lcdsp_host_port

`default_nettype wire

// File: testbench/lcdsp_host_model.sv
// Purpose: Host microcontroller acting as serial bus master
// Assumes: Serial clock half period of eight sys_clk cycles
// Notes:   Drives the pins at sys_clk rising edges only
`timescale 1ns/100ps
`default_nettype none

module lcdsp_host_model (
  // Clock
  input  wire logic sys_clk,
  // Device answer
  input  wire logic serialOutPin,
  input  wire logic serialOutEn,
  // Host drive
  output var  logic chipSelectN,
  output var  logic serialClk,
  output var  logic dataCmdPin,
  output wire logic serialData
);
  logic hostEn  = 1'b1;
  logic hostBit = 1'b0;
  logic lastBit = 1'b0;

  initial
  begin
    chipSelectN = 1'b1;
    serialClk   = 1'b0;
    dataCmdPin  = 1'b0;
  end

  // Shared pad; a released pad toggles so it never looks like data
  assign serialData = hostEn ? hostBit : serialOutEn ? serialOutPin : ~lastBit;

  always @(posedge sys_clk)
    lastBit <= serialData;

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_clk

  task automatic select(input logic on);
    @(posedge sys_clk);
    serialClk   <= 1'b0;
    chipSelectN <= ~on;
    hostEn      <= 1'b1;
    wait_clk(6);
  endtask : select

  task automatic send(input logic [8:0] val, input int n, input logic dc,
                      input logic rel);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge sys_clk);
      hostBit    <= val[i];
      dataCmdPin <= dc;
      wait_clk(7);
      serialClk <= 1'b1;
      wait_clk(8);
      serialClk <= 1'b0;
      if (rel && i == 0)
        hostEn <= 1'b0;
    end
  endtask : send

  task automatic get(output logic [7:0] val, output logic en);
    en = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      wait_clk(8);
      serialClk <= 1'b1;
      val[i] = serialOutPin;
      en &= serialOutEn;
      wait_clk(8);
      serialClk <= 1'b0;
    end
  endtask : get
endmodule : lcdsp_host_model

`default_nettype wire

// File: testbench/tb_lcd_driver_serial_host_port.sv
// Purpose: Self-checking bench of the serial host port
// Assumes: Host model drives the serial pins
// Notes:   Address counter state is carried from case to case
`timescale 1ns/100ps
`default_nettype none
`include "lcdsp_params.svh"

module tb_lcd_driver_serial_host_port;
  localparam logic ID_A = 1'b1; // Arbitrary identity value
  localparam logic ID_B = 1'b0; // Arbitrary identity value
  typedef struct packed {
    logic [1:0] sel;
    logic       hf;
    logic       vf;
    logic       isData;
    logic [7:0] b;
    logic [6:0] col;
    logic [4:0] bank;
  } lcdsp_row_t;
  lcdsp_row_t rows [5] = '{
    '{`LCDSP_SEL_SPI4, 1'b0, 1'b0, 1'b0, 8'hA5, 7'h00, 5'h00},
    '{`LCDSP_SEL_SPI4, 1'b0, 1'b0, 1'b1, 8'h3C, 7'h00, 5'h00},
    '{`LCDSP_SEL_SPI4, 1'b1, 1'b0, 1'b1, 8'hC3, 7'h5E, 5'h00},
    '{`LCDSP_SEL_SER9, 1'b0, 1'b1, 1'b1, 8'h81, 7'h02, 5'h10},
    '{`LCDSP_SEL_SER9, 1'b0, 1'b0, 1'b0, 8'h7E, 7'h00, 5'h00}};
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic hwResetN = 1'b1;
  logic [1:0] sel = `LCDSP_SEL_SPI4;
  logic hFlip = 1'b0;
  logic vFlip = 1'b0;
  logic sLow = 1'b1;
  logic sHigh = 1'b0;
  logic vMode = 1'b1;
  logic [6:0] temp = 7'h5A;
  wire logic csN, sck, sDat, dcPin, outPin, outEn, cmdValid, ramWrValid;
  wire logic [7:0] cmdByte;
  lcdsp_pkg::lcdsp_ram_wr_t ramWrite;
  logic [7:0] cmdQ [$];
  logic [7:0] eCmd [$];
  logic [19:0] ramQ [$];
  logic [19:0] eRam [$];
  logic [6:0] expRd [6];
  logic [7:0] rd;
  logic en;
  int errors = 0;
  int nChecks = 0;

  always #5 sys_clk = ~sys_clk;

  lcdsp_host_port #(.FIXED_ID_A(ID_A), .FIXED_ID_B(ID_B)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .chipSelectN(csN),
    .serialClk(sck), .serialInPin(sDat), .dataCmdPin(dcPin),
    .hardwareResetN(hwResetN), .serialOutPin(outPin),
    .serialOutEn(outEn), .interfaceSelectPins(sel),
    .horizontalFlipPin(hFlip), .strapPadLow(sLow), .strapPadHigh(sHigh),
    .verticalFlipBit(vFlip), .voltageModeReadback(vMode),
    .temperatureCode(temp), .cmdValid(cmdValid), .cmdByte(cmdByte),
    .ramWrValid(ramWrValid), .ramWrite(ramWrite));

  lcdsp_host_model model_u (
    .sys_clk(sys_clk), .serialOutPin(outPin), .serialOutEn(outEn),
    .chipSelectN(csN), .serialClk(sck), .dataCmdPin(dcPin),
    .serialData(sDat));

  always @(posedge sys_clk)
  begin
    if (cmdValid === 1'b1)
      cmdQ.push_back(cmdByte);
    if (ramWrValid === 1'b1)
      ramQ.push_back(ramWrite);
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp,
                       input string msg);
    nChecks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic complete_run;
    if (errors == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic compare_queues;
    model_u.wait_clk(12);
    check(20'(cmdQ.size()), 20'(eCmd.size()), "command count");
    check(20'(ramQ.size()), 20'(eRam.size()), "write count");
    foreach (eCmd[i]) check(20'(cmdQ[i]), 20'(eCmd[i]), "command");
    foreach (eRam[i]) check(ramQ[i], eRam[i], "ram write");
    cmdQ = {};
    eCmd = {};
    ramQ = {};
    eRam = {};
  endtask : compare_queues

  task automatic put(input logic d, input logic [7:0] b, input logic rel);
    if (sel === `LCDSP_SEL_SER9)
      model_u.send({d, b}, 9, d, rel);
    else
      model_u.send({1'b0, b}, 8, d, rel);
  endtask : put

  // Hang guard
  initial
  begin
    #500000;
    errors++;
    complete_run();
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    model_u.wait_clk(1);
    check(20'({cmdValid, ramWrValid, outEn}), 20'h0_0000,
          "reset outputs");
    model_u.wait_clk(4);
    // ************************************************************
    // Table cases
    // ************************************************************
    foreach (rows[i])
    begin
      @(posedge sys_clk);
      sel   <= rows[i].sel;
      hFlip <= rows[i].hf;
      vFlip <= rows[i].vf;
      model_u.select(1'b1);
      put(rows[i].isData, rows[i].b, 1'b0);
      model_u.select(1'b0);
      if (rows[i].isData)
        eRam.push_back({rows[i].col, rows[i].bank, rows[i].b});
      else
        eCmd.push_back(rows[i].b);
      compare_queues();
    end
    // ************************************************************
    // Awkward cases
    // ************************************************************
    sel <= `LCDSP_SEL_SPI4;
    model_u.select(1'b1);
    put(1'b0, 8'hE1, 1'b0);
    put(1'b0, 8'h5F, 1'b0);
    put(1'b0, 8'h30, 1'b0);
    put(1'b1, 8'hAA, 1'b0);
    put(1'b1, 8'h55, 1'b0);
    model_u.select(1'b0);
    eRam = '{{7'h5F, 5'h10, 8'hAA}, {7'h00, 5'h00, 8'h55}};
    compare_queues();
    sel <= `LCDSP_SEL_SPI3;
    model_u.select(1'b1);
    put(1'b0, 8'hE0, 1'b0);
    put(1'b0, 8'h02, 1'b0);
    put(1'b0, 8'h11, 1'b0);
    put(1'b0, 8'h22, 1'b0);
    put(1'b0, 8'h77, 1'b0);
    model_u.select(1'b0);
    eRam = '{{7'h01, 5'h00, 8'h11}, {7'h02, 5'h00, 8'h22}};
    eCmd = '{8'h77};
    compare_queues();
    model_u.select(1'b1);
    put(1'b0, 8'hE0, 1'b0);
    put(1'b0, 8'h03, 1'b0);
    put(1'b0, 8'h33, 1'b0);
    model_u.send(9'h00F, 4, 1'b0, 1'b0);
    model_u.select(1'b0);
    model_u.select(1'b1);
    put(1'b0, 8'h66, 1'b0);
    model_u.select(1'b0);
    eRam = '{{7'h03, 5'h00, 8'h33}};
    eCmd = '{8'h66};
    compare_queues();
    model_u.send(9'h0A5, 8, 1'b0, 1'b0);
    sel <= `LCDSP_SEL_I2C;
    model_u.select(1'b1);
    put(1'b0, 8'hA5, 1'b0);
    model_u.select(1'b0);
    compare_queues();
    sel <= `LCDSP_SEL_SER9;
    model_u.select(1'b1);
    model_u.send(9'h01E, 5, 1'b0, 1'b0);
    hwResetN <= 1'b0;
    model_u.wait_clk(6);
    hwResetN <= 1'b1;
    model_u.wait_clk(6);
    put(1'b0, 8'h42, 1'b0);
    put(1'b1, 8'h99, 1'b0);
    model_u.select(1'b0);
    eCmd = '{8'h42};
    eRam = '{{7'h00, 5'h00, 8'h99}};
    compare_queues();
    for (int p = 0; p < 2; p++)
    begin
      // Second pass flips every readback source except the two fixed identity bits
      sLow  <= ~p[0];
      sHigh <= p[0];
      vMode <= ~p[0];
      temp  <= p[0] ? 7'h25 : 7'h5A;
      model_u.wait_clk(1);
      expRd = '{{7{ID_A}}, {7{ID_B}}, {7{sLow}}, {7{sHigh}}, {7{vMode}},
                temp};
      for (int i = 0; i < 6; i++)
      begin
        sel <= (i == 5) ? `LCDSP_SEL_SER9
             : p[0] ? `LCDSP_SEL_SPI3 : `LCDSP_SEL_SPI4;
        model_u.select(1'b1);
        put(1'b0, 8'hD0 + 8'(i), 1'b1);
        model_u.get(rd, en);
        model_u.wait_clk(6);
        check(20'(rd[6:0]), 20'(expRd[i]), "read byte");
        check(20'(en), 20'h0_0001, "output enable in read");
        check(20'(outEn), 20'h0_0000, "output released");
        model_u.select(1'b0);
      end
    end
    compare_queues();
    complete_run();
  end
endmodule : tb_lcd_driver_serial_host_port

`default_nettype wire
